// ===== test/lin_far_end.sv
// Far-side model: controller transmit pin and the wired LIN bus
`timescale 1ns/100ps
module lin_far_end
(
    input  wire logic txBit,          // Bit the controller sends, 0 = dominant
    input  wire logic clampLow,       // Bus held dominant by a fault
    input  wire logic linTxDominant,  // Transceiver drives dominant
    output logic      linTxIn,
    output logic      linBusIn
);
    // Controller pin follows its bit
    assign linTxIn = txBit;
    // Bus with pull-up: recessive unless a party pulls it down
    assign linBusIn = ~(linTxDominant | clampLow);
endmodule : lin_far_end

// ===== test/lin_sup_props.sv
// Concurrent checks on the LIN supervisor ports
`timescale 1ns/100ps
module lin_sup_props
    import lin_sup_pkg::*;
#(parameter int unsigned TX_DOM_CNT = 50)
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire sys_mode_t   sysMode,
    input wire logic        sysResetOutN,
    input wire logic        linTxIn,
    input wire logic        linTxEnable,
    input wire logic        linTxDominant,
    input wire logic        linRxEnable,
    input wire term_t       linTermPin,
    input wire logic        irqOutN,
    input wire logic        irqOutNOe
);
    int unsigned txLowCnt_q;  // Cycles the transmit input has been dominant
    // Count a dominant run on the transmit input
    always_ff @(posedge clk_sys)
    begin
        txLowCnt_q <= (rst || linTxIn) ? 0 : txLowCnt_q + 1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Read of the interrupt register taken on the bus
    sequence irqRead;
        hsel && hready && htrans[1] && !hwrite && haddr == {20'h0_0000, OFF_IRQ};
    endsequence
    irq_pin_low_a:
        assert property (irqOutN == 1'b0) else $error("interrupt pin data not low");
    rx_with_tx_a:
        assert property (linTxEnable |-> linRxEnable) else $error("transmitter on while off-line");
    tx_dom_cause_a:
        assert property (linTxDominant |-> linTxEnable && !$past(linTxIn)) else $error("dominant without cause");
    active_term_a:
        assert property (linRxEnable |-> linTermPin inside {TERM_ON, TERM_WEAK}) else $error("active termination");
    offline_term_a:
        assert property (!linRxEnable |-> linTermPin == TERM_OFF) else $error("off-line termination");
    active_gate_a:
        assert property ($rose(linRxEnable) |-> $past(sysMode, 2) != SYS_OTHER) else $error("active in wrong mode");
    tx_clamp_a:
        assert property (txLowCnt_q > TX_DOM_CNT + 4 |-> !linTxEnable) else $error("transmit clamp not cut");
    read_hold_a:
        assert property (irqRead |-> ##2 (!irqOutNOe) [*8]) else $error("pin not high after read");
    reset_clear_a:
        assert property ($fell(sysResetOutN) |-> ##[0:2] !irqOutNOe) else $error("reset left interrupt");
endmodule : lin_sup_props
bind lin_transceiver_supervisor lin_sup_props #(.TX_DOM_CNT(TX_DOM_CNT)) u_lin_sup_props (.clk_sys, .rst, .hsel,
    .haddr, .htrans, .hwrite, .hready, .sysMode, .sysResetOutN, .linTxIn, .linTxEnable, .linTxDominant,
    .linRxEnable, .linTermPin, .irqOutN, .irqOutNOe);

// ===== test/lin_transceiver_supervisor_tb.sv
// Self-checking bench for the LIN supervisor
`timescale 1ns/100ps
module lin_transceiver_supervisor_tb;
    import lin_sup_pkg::*;
    logic clk_sys = 0, rst = 1, hsel = 0, hwrite = 0, txBit = 1, clampLow = 0;
    logic ce = 1, wdTick = 0, sysRstInN = 1, wakeIn = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    sys_mode_t sysMode = SYS_FLASH;
    logic hreadyout, hresp, sysResetOutN, linTxIn, linBusIn, linRxOut, linTxEnable, linTxDominant;
    logic linRxEnable, linSlopeSelect, linDriveBoost, irqOutN, irqOutNOe;
    term_t linTermPin;
    int miscompares = 0, samples_checked = 0;
    always #12.5 clk_sys = ~clk_sys;
    lin_transceiver_supervisor #(.TX_DOM_CNT(50), .BUS_DOM_CNT(100), .READOUT_CNT(2000)) u_lin_transceiver_supervisor (
        .clk_sys, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .sysMode, .wdPeriodTick(wdTick), .sysResetInN(sysRstInN), .sysResetOutN,
        .linTxIn, .linBusIn, .linWakeIn(wakeIn), .linRxOut, .linTxEnable, .linTxDominant, .linRxEnable,
        .linTermPin, .linSlopeSelect, .linDriveBoost, .irqOutN, .irqOutNOe);
    lin_far_end u_lin_far_end (.txBit, .clampLow, .linTxDominant, .linTxIn, .linBusIn);
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Wait at most 20 edges for the slave to be ready
    task automatic rdy;
        for (int n = 0; n < 20; n++)
        begin
            @(posedge clk_sys);
            if (hreadyout === 1'b1)
                return;
        end
        miscompares++;
        conclude();
    endtask : rdy
    // One single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        r = hrdata;
    endtask : bus
    task automatic t_regs;
        bus(0, OFF_CTRL, 0, rd);
        chk("ctrl reset", rd, 32'h0000_0000);
        bus(0, OFF_STATUS, 0, rd);
        chk("status reset", rd, 32'h0000_0000);
        chk("okay response", hresp, 0);
        bus(0, 12'h010, 0, rd);
        chk("unmapped read", rd, 32'h0000_0000);
        bus(1, OFF_CTRL, 32'h0000_000C, rd);
        repeat (3) @(posedge clk_sys);
        chk("slope and boost", {linSlopeSelect, linDriveBoost}, 32'h0000_0003);
        bus(1, OFF_CTRL, 32'h0000_0004, rd);
        repeat (3) @(posedge clk_sys);
        chk("slope only", {linSlopeSelect, linDriveBoost}, 32'h0000_0002);
        $display("test regs done");
    endtask : t_regs
    task automatic t_active;
        bus(1, OFF_IRQEN, 32'h0000_0007, rd);
        bus(1, OFF_CTRL, 32'h0000_0003, rd);
        repeat (4) @(posedge clk_sys);
        chk("rx enable", linRxEnable, 1);
        chk("listen only", linTxEnable, 0);
        chk("term on", linTermPin, TERM_ON);
        bus(1, OFF_CTRL, 32'h0000_0001, rd);
        repeat (4) @(posedge clk_sys);
        chk("tx enable", linTxEnable, 1);
        ce <= 1'b0;
        sysMode <= SYS_OTHER;
        repeat (4) @(posedge clk_sys);
        chk("frozen", linRxEnable, 1);
        ce <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk("left active", {linRxEnable, linTxEnable, linTermPin}, 32'h0000_0000);
        wakeIn <= 1'b1;
        @(posedge clk_sys);
        wakeIn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("wake on rx", linRxOut, 0);
        sysMode <= SYS_FLASH;
        repeat (4) @(posedge clk_sys);
        chk("rx follows bus", linRxOut, 1);
        $display("test active done");
    endtask : t_active
    task automatic t_txclamp;
        txBit <= 1'b0;
        repeat (60) @(posedge clk_sys);
        chk("tx cut", linTxEnable, 0);
        bus(0, OFF_STATUS, 0, rd);
        chk("fail bits", rd[2:0], 32'h0000_0004);
        chk("pin asserted", irqOutNOe, 1);
        bus(0, OFF_IRQ, 0, rd);
        chk("irq flags", rd, 32'h0000_0004);
        repeat (3) @(posedge clk_sys);
        chk("pin released", irqOutNOe, 0);
        txBit <= 1'b1;
        bus(1, OFF_CTRL, 32'h0000_0003, rd);
        bus(1, OFF_CTRL, 32'h0000_0001, rd);
        repeat (4) @(posedge clk_sys);
        chk("tx back", linTxEnable, 1);
        bus(0, OFF_IRQ, 0, rd);
        chk("recovery flag", rd, 32'h0000_0004);
        $display("test tx clamp done");
    endtask : t_txclamp
    task automatic t_timeout;
        clampLow <= 1'b1;
        repeat (110) @(posedge clk_sys);
        chk("term weak", linTermPin, TERM_WEAK);
        bus(0, OFF_STATUS, 0, rd);
        chk("ground fail", rd[0], 1);
        repeat (400) @(posedge clk_sys);
        chk("pin asserted late", irqOutNOe, 1);
        sysRstInN <= 1'b0;
        @(posedge clk_sys);
        sysRstInN <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk("sys reset clears", irqOutNOe, 0);
        sysMode <= SYS_NORMAL;
        wdTick <= 1'b1;
        @(posedge clk_sys);
        wdTick <= 1'b0;
        clampLow <= 1'b0;
        for (int i = 0; i < 2500 && sysResetOutN === 1'b1; i++)
            @(posedge clk_sys);
        chk("system reset", sysResetOutN, 0);
        repeat (50) @(posedge clk_sys);
        $display("test timeout done");
    endtask : t_timeout
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_active();
        t_txclamp();
        t_timeout();
        conclude();
    end
endmodule : lin_transceiver_supervisor_tb

// ===== verilog/lin_sup_pkg.sv
// Package with register map, field layout, timing constants and carrier types for the LIN supervisor
package lin_sup_pkg;

    // ------------------------------------------------------------
    // Register byte offsets on the AHB-Lite bus
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL   = 12'h000;   // Transceiver control bits
    localparam logic [11:0] OFF_IRQEN  = 12'h004;   // Failure interrupt enables
    localparam logic [11:0] OFF_IRQ    = 12'h008;   // Interrupt flags, cleared on read
    localparam logic [11:0] OFF_STATUS = 12'h00C;   // Live transceiver state

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_ACTIVE_REQ  = 0;   // lin_active_request
    localparam int CTRL_TX_INHIBIT  = 1;   // lin_tx_inhibit
    localparam int CTRL_SLOPE       = 2;   // lin_slope_select (1 = low slope)
    localparam int CTRL_BOOST       = 3;   // lin_drive_boost
    localparam int FAIL_GND         = 0;   // Bus shorted to ground
    localparam int FAIL_BAT         = 1;   // Bus shorted to battery
    localparam int FAIL_TXD         = 2;   // Transmit input clamped dominant
    localparam int ST_ACTIVE        = 3;   // Status: Active mode
    localparam int ST_TERM_LSB      = 4;   // Status: termination state, two bits
    localparam int ST_WAKE          = 6;   // Status: wake-up seen off-line
    localparam int NUM_FAIL         = 3;   // Failure sources

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [3:0]          CTRL_RESET  = 4'h0;
    localparam logic [NUM_FAIL-1:0] IRQEN_RESET = 3'h0;

    // ------------------------------------------------------------
    // Timing: figures in microseconds, counts at the 40 MHz clock
    // ------------------------------------------------------------
    localparam int CLK_MHZ              = 40;
    localparam int TX_DOM_TIMEOUT_US    = 20000;   // tx_dominant_timeout
    localparam int BUS_DOM_DETECT_US    = 40000;   // Bus-dominant detection, longer than the above
    localparam int IRQ_MIN_HIGH_US      = 10;      // irq_min_high_time
    localparam int IRQ_READOUT_US       = 256000;  // irq_readout_timeout
    localparam int TX_DOM_CYCLES        = TX_DOM_TIMEOUT_US * CLK_MHZ;
    localparam int BUS_DOM_CYCLES       = BUS_DOM_DETECT_US * CLK_MHZ;
    localparam int IRQ_MIN_HIGH_CYCLES  = IRQ_MIN_HIGH_US * CLK_MHZ;
    localparam int IRQ_READOUT_CYCLES   = IRQ_READOUT_US * CLK_MHZ;
    localparam int LOOP_DELAY_CYCLES    = 16;      // Allowed transmit-to-bus loop delay
    localparam int RESET_PULSE_CYCLES   = 40;      // Length of the system reset pulse

    // ------------------------------------------------------------
    // Enumerations and carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SYS_OTHER, SYS_NORMAL, SYS_FLASH} sys_mode_t;
    typedef enum logic [1:0] {TERM_OFF, TERM_ON, TERM_WEAK} term_t;
    typedef enum logic {LIN_OFFLINE, LIN_ACTIVE} lin_mode_t;

    typedef struct packed {
        logic boost;      // Increased driver capability
        logic slope;      // Low slope when set
        logic inhibit;    // Listen-only
        logic activeReq;  // Request Active mode
    } ctrl_t;

endpackage : lin_sup_pkg

// ===== verilog/lin_transceiver_supervisor.sv
// LIN transceiver mode control, clamp supervision, termination and interrupt pin, with AHB-Lite registers
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
module lin_transceiver_supervisor
    import lin_sup_pkg::*;
#(
    parameter int unsigned TX_DOM_CNT   = TX_DOM_CYCLES,        // Transmit clamp time in cycles
    parameter int unsigned BUS_DOM_CNT  = BUS_DOM_CYCLES,       // Bus clamp time in cycles
    parameter int unsigned READOUT_CNT  = IRQ_READOUT_CYCLES    // Interrupt read-out timeout in cycles
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // System side
    input  wire sys_mode_t   sysMode,
    input  wire logic        wdPeriodTick,
    input  wire logic        sysResetInN,
    output logic             sysResetOutN,
    // LIN pins and analog controls
    input  wire logic        linTxIn,
    input  wire logic        linBusIn,
    input  wire logic        linWakeIn,
    output logic             linRxOut,
    output logic             linTxEnable,
    output logic             linTxDominant,
    output logic             linRxEnable,
    output term_t            linTermPin,
    output logic             linSlopeSelect,
    output logic             linDriveBoost,
    // Open-drain interrupt pin
    output logic             irqOutN,
    output logic             irqOutNOe
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // Matches a word-aligned byte address, latched or live, against a register offset
    function automatic logic regHit(input logic [11:0] addr, input logic [11:0] off);
        regHit = (addr == off);
    endfunction : regHit

    // Saturating counter step, held at the limit
    function automatic logic [31:0] countUp(input logic [31:0] cnt, input logic [31:0] lim);
        countUp = (cnt >= lim) ? lim : cnt + 32'h0000_0001;
    endfunction : countUp

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ctrl_t                 ctrl_q;            // Software control bits
    logic [NUM_FAIL-1:0]   irqEn_q;           // Interrupt enables
    logic [NUM_FAIL-1:0]   irqFlag_q;         // Interrupt flags
    logic [NUM_FAIL-1:0]   fail_q;            // Live failure status
    logic [NUM_FAIL-1:0]   failPrev_q;        // Status one cycle ago
    logic [NUM_FAIL-1:0]   used_q;            // Sources fired this watchdog period
    lin_mode_t             mode_q;            // Transceiver mode
    logic                  wake_q;            // Wake seen while off-line
    logic                  inhPrev_q;         // Inhibit bit one cycle ago
    logic                  busPrev_q;         // Bus level one cycle ago
    logic [31:0]           txDomCnt_q;        // Transmit dominant time
    logic [31:0]           busDomCnt_q;       // Bus dominant time
    logic [31:0]           loopCnt_q;         // Transmit dominant with bus recessive
    logic [31:0]           highCnt_q;         // Interrupt pin minimum high time
    logic [31:0]           readoutCnt_q;      // Pending interrupt age
    logic [31:0]           rstPulse_q;        // Remaining reset pulse cycles
    logic                  wrPend_q;          // Write data phase pending
    logic [11:0]           addr_q;            // Latched address

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        addrPhase   = ce & hsel & hready & htrans[1];
    wire        busWrite    = addrPhase & hwrite;
    wire        busRead     = addrPhase & ~hwrite;
    wire [11:0] addrNow     = {haddr[11:2], 2'b00};
    wire        rdIrqHit    = busRead & (haddr[31:12] == 20'h0_0000) & regHit(addrNow, OFF_IRQ);
    wire        wrCtrl      = wrPend_q & regHit(addr_q, OFF_CTRL);
    wire        wrIrqEn     = wrPend_q & regHit(addr_q, OFF_IRQEN);
    wire        addrMapped  = (haddr[31:12] == 20'h0_0000);

    // ------------------------------------------------------------
    // Mode and transmitter decode
    // ------------------------------------------------------------
    wire        sysAllows   = (sysMode == SYS_NORMAL) | (sysMode == SYS_FLASH);
    wire        activeNext  = ctrl_q.activeReq & sysAllows;
    wire        isActive    = (mode_q == LIN_ACTIVE);
    wire        txDom       = ~linTxIn;
    wire        busDom      = ~linBusIn;
    wire        busEdge     = busPrev_q ^ linBusIn;
    wire        inhToggled  = inhPrev_q & ~ctrl_q.inhibit;                 // Set then cleared
    wire        txOn        = isActive & ~ctrl_q.inhibit & ~fail_q[FAIL_TXD] & ~fail_q[FAIL_BAT];
    wire        sysResetAll = ~sysResetInN | (rstPulse_q != 32'h0000_0000);

    // ------------------------------------------------------------
    // Failure detection decode
    // ------------------------------------------------------------
    wire        txClampSet  = isActive & txDom & (txDomCnt_q >= 32'(TX_DOM_CNT));
    wire        txClampClr  = ~txDom & (busEdge | inhToggled);
    wire        gndSet      = busDom & (busDomCnt_q >= 32'(BUS_DOM_CNT));
    wire        gndClr      = ~busDom;
    wire        batSet      = txOn & txDom & ~busDom & (loopCnt_q >= 32'(LOOP_DELAY_CYCLES));
    wire        batClr      = busDom | inhToggled;
    wire [NUM_FAIL-1:0] failD;
    assign failD[FAIL_TXD] = txClampSet | (fail_q[FAIL_TXD] & ~txClampClr);
    assign failD[FAIL_GND] = gndSet | (fail_q[FAIL_GND] & ~gndClr);
    assign failD[FAIL_BAT] = batSet | (fail_q[FAIL_BAT] & ~batClr);

    // ------------------------------------------------------------
    // Interrupt decode
    // ------------------------------------------------------------
    wire [NUM_FAIL-1:0] failChg   = fail_q ^ failPrev_q;
    wire [NUM_FAIL-1:0] limited   = (sysMode == SYS_NORMAL) ? used_q : '0;
    wire [NUM_FAIL-1:0] irqSet    = failChg & irqEn_q & ~limited;
    wire [NUM_FAIL-1:0] irqClr    = rdIrqHit ? {NUM_FAIL{1'b1}} : '0;
    wire [NUM_FAIL-1:0] irqFlagD  = irqSet | (irqFlag_q & ~irqClr);                       // Set wins
    wire                pending   = |irqFlag_q;
    wire                holdHigh  = (highCnt_q != 32'h0000_0000);
    wire                timeout   = pending & (readoutCnt_q >= 32'(READOUT_CNT));

    // ------------------------------------------------------------
    // Termination decode
    // ------------------------------------------------------------
    term_t termD;
    assign termD = fail_q[FAIL_GND] ? TERM_WEAK
                 : isActive         ? TERM_ON
                 :                    TERM_OFF;

    // ------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------
    wire [31:0] ctrlRd   = {28'h000_0000, ctrl_q};
    wire [31:0] enRd     = {29'h0000_0000, irqEn_q};
    wire [31:0] flagRd   = {29'h0000_0000, irqFlag_q};
    wire [31:0] statRd   = {25'h000_0000, wake_q, termD, isActive, fail_q};
    wire [31:0] rdData   = ~addrMapped                  ? 32'h0000_0000
                         : regHit(addrNow, OFF_CTRL)   ? ctrlRd
                         : regHit(addrNow, OFF_IRQEN)  ? enRd
                         : regHit(addrNow, OFF_IRQ)    ? flagRd
                         : regHit(addrNow, OFF_STATUS) ? statRd
                         :                               32'h0000_0000;

    // ------------------------------------------------------------
    // Bus slave: zero wait states, OKAY always
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPend_q  <= 1'b0;
            addr_q    <= 12'h000;
        end
        else if (ce)
        begin
            // Capture read data at the address phase so it stands in the data phase
            hrdata    <= busRead ? rdData : 32'h0000_0000;
            wrPend_q  <= busWrite & addrMapped;
            addr_q    <= addrNow;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl_q    <= ctrl_t'(CTRL_RESET);
            irqEn_q   <= IRQEN_RESET;
            inhPrev_q <= 1'b0;
        end
        else if (ce)
        begin
            // Write data is taken in the data phase
            if (wrCtrl)
            begin
                ctrl_q <= ctrl_t'(hwdata[3:0]);
            end
            if (wrIrqEn)
            begin
                irqEn_q <= hwdata[NUM_FAIL-1:0];
            end
            inhPrev_q <= ctrl_q.inhibit;
        end
    end

    // ------------------------------------------------------------
    // Mode control
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mode_q <= LIN_OFFLINE;
            wake_q <= 1'b0;
        end
        else if (ce)
        begin
            // Only two modes exist
            mode_q <= activeNext ? LIN_ACTIVE : LIN_OFFLINE;
            // Wake latch is cleared by going Active, else set by the wake receiver
            if (activeNext)
            begin
                wake_q <= 1'b0;
            end
            else if (linWakeIn)
            begin
                wake_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Clamp timers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            txDomCnt_q  <= 32'h0000_0000;
            busDomCnt_q <= 32'h0000_0000;
            loopCnt_q   <= 32'h0000_0000;
            busPrev_q   <= 1'b1;
        end
        else if (ce)
        begin
            // Each timer runs while its condition stands, else restarts
            txDomCnt_q  <= txDom ? countUp(txDomCnt_q, 32'(TX_DOM_CNT)) : 32'h0000_0000;
            busDomCnt_q <= busDom ? countUp(busDomCnt_q, 32'(BUS_DOM_CNT)) : 32'h0000_0000;
            loopCnt_q   <= (txOn & txDom & ~busDom) ? countUp(loopCnt_q, 32'(LOOP_DELAY_CYCLES))
                                                     : 32'h0000_0000;
            busPrev_q   <= linBusIn;
        end
    end

    // ------------------------------------------------------------
    // Failure status
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            fail_q     <= '0;
            failPrev_q <= '0;
        end
        else if (ce)
        begin
            fail_q     <= failD;
            failPrev_q <= fail_q;
        end
    end

    // ------------------------------------------------------------
    // Interrupt flags and watchdog-period limiter
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            irqFlag_q <= '0;
            used_q    <= '0;
        end
        else if (ce)
        begin
            // System reset empties the register
            if (sysResetAll)
            begin
                irqFlag_q <= '0;
            end
            else
            begin
                irqFlag_q <= irqFlagD;
            end
            // Period tick frees every source again
            if (wdPeriodTick)
            begin
                used_q <= '0;
            end
            else
            begin
                used_q <= used_q | irqSet;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt pin timing and read-out watchdog
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            highCnt_q    <= 32'h0000_0000;
            readoutCnt_q <= 32'h0000_0000;
            rstPulse_q   <= 32'h0000_0000;
        end
        else if (ce)
        begin
            // Every read of the flags restarts the high time
            if (rdIrqHit)
            begin
                highCnt_q <= 32'(IRQ_MIN_HIGH_CYCLES);
            end
            else if (holdHigh)
            begin
                highCnt_q <= highCnt_q - 32'h0000_0001;
            end
            // Age of the pending interrupt
            if (~pending | rdIrqHit)
            begin
                readoutCnt_q <= 32'h0000_0000;
            end
            else
            begin
                readoutCnt_q <= countUp(readoutCnt_q, 32'(READOUT_CNT));
            end
            // Reset pulse on timeout
            if (timeout & (rstPulse_q == 32'h0000_0000))
            begin
                rstPulse_q <= 32'(RESET_PULSE_CYCLES);
            end
            else if (rstPulse_q != 32'h0000_0000)
            begin
                rstPulse_q <= rstPulse_q - 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin outputs, all registered
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            linRxOut       <= 1'b1;
            linTxEnable    <= 1'b0;
            linTxDominant  <= 1'b0;
            linRxEnable    <= 1'b0;
            linTermPin     <= TERM_OFF;
            linSlopeSelect <= 1'b0;
            linDriveBoost  <= 1'b0;
            irqOutN        <= 1'b0;
            irqOutNOe      <= 1'b0;
            sysResetOutN   <= 1'b1;
        end
        else if (ce)
        begin
            // Receiver follows bus when Active, inverted wake latch when off-line
            linRxOut       <= isActive ? linBusIn : ~wake_q;
            linTxEnable    <= txOn;
            linTxDominant  <= txOn & txDom;
            linRxEnable    <= isActive;
            linTermPin     <= termD;
            linSlopeSelect <= ctrl_q.slope;
            linDriveBoost  <= ctrl_q.boost;
            irqOutN        <= 1'b0;
            irqOutNOe      <= pending & ~holdHigh & ~rdIrqHit;
            sysResetOutN   <= ~(timeout | (rstPulse_q > 32'h0000_0001));
        end
    end

endmodule : lin_transceiver_supervisor
